/* File: scamap_pkg.sv */
// Constants and types shared by the command and address mapper
`default_nettype none
package scamap_pkg;
  localparam int CODE_W = 10;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  localparam int FILE_W = 8;
  localparam int ELEM_W = 16;
  localparam int PROD_W = 24;
  localparam int NUM_RG = 10;

  // Local function codes
  localparam logic [9:0] FC_PROT_WR   = 10'h001;
  localparam logic [9:0] FC_UNP_RD    = 10'h002;
  localparam logic [9:0] FC_PROT_BIT  = 10'h003;
  localparam logic [9:0] FC_UNP_BIT   = 10'h004;
  localparam logic [9:0] FC_RNG_WR_B  = 10'h064;
  localparam logic [9:0] FC_RNG_RD_B  = 10'h065;
  localparam logic [9:0] FC_RMW_B     = 10'h066;
  localparam logic [9:0] FC_ASCII_OFS = 10'h032;
  localparam logic [9:0] FC_RNG_WR_A  = FC_RNG_WR_B + FC_ASCII_OFS;
  localparam logic [9:0] FC_RMW_A     = FC_RMW_B + FC_ASCII_OFS;
  localparam logic [9:0] FC_TLR2      = 10'h1f5;
  localparam logic [9:0] FC_TLR3      = 10'h1f6;
  localparam logic [9:0] FC_TLW2      = 10'h1fd;
  localparam logic [9:0] FC_TLW3      = 10'h1fe;
  localparam logic [9:0] FC_TLWM      = 10'h1ff;

  // Link command and function bytes
  localparam logic [7:0] CB_PROT_WR  = 8'h00;
  localparam logic [7:0] CB_UNP_RD   = 8'h01;
  localparam logic [7:0] CB_PROT_BIT = 8'h02;
  localparam logic [7:0] CB_UNP_BIT  = 8'h05;
  localparam logic [7:0] CB_EXT      = 8'h0f;
  localparam logic [7:0] FB_NONE     = 8'h00;
  localparam logic [7:0] FB_RNG_WR   = 8'h00;
  localparam logic [7:0] FB_RNG_RD   = 8'h01;
  localparam logic [7:0] FB_RMW      = 8'h26;
  localparam logic [7:0] FB_TLR2     = 8'ha1;
  localparam logic [7:0] FB_TLR3     = 8'ha2;
  localparam logic [7:0] FB_TLW2     = 8'ha9;
  localparam logic [7:0] FB_TLW3     = 8'haa;
  localparam logic [7:0] FB_TLWM     = 8'hab;

  // File emulation defaults and database extent
  localparam logic [7:0]  DEF_FIRST_FILE = 8'h07;
  localparam logic [15:0] DEF_FILE_SIZE  = 16'h00c8;
  localparam logic [13:0] DB_LAST        = 14'h270f;

  typedef enum logic [3:0] {
    RG_USER, RG_BP_CFG, RG_P1_SETUP, RG_P2_SETUP, RG_RSVD_LO,
    RG_P1_CMDS, RG_P2_CMDS, RG_STATUS, RG_CMD_CTRL, RG_RSVD_HI,
    RG_NONE = 4'hf
  } scamap_region_e;

  localparam logic [13:0] RG_START [NUM_RG] = '{
    14'h0000, 14'h1388, 14'h1392, 14'h13b0, 14'h13ce,
    14'h1450, 14'h1900, 14'h1db0, 14'h1e78, 14'h1f40};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MAP  = 2'b01,
    ST_ACC  = 2'b11,
    ST_RESP = 2'b10
  } scamap_state_e;
endpackage
`default_nettype wire

/* File: scamap_ifs.sv */
// Carriers between the mapper top and its two helpers
`default_nettype none
interface scamap_xlat_if import scamap_pkg::*; ();
  logic [CODE_W-1:0] code;
  logic [7:0]        cmd;
  logic [7:0]        fn;
  logic              fn_used;
  logic              ascii;
  logic              known;
  modport user (output code, input cmd, fn, fn_used, ascii, known);
  modport xlat (input code, output cmd, fn, fn_used, ascii, known);
endinterface

interface scamap_map_if import scamap_pkg::*; ();
  logic [FILE_W-1:0] file;
  logic [FILE_W-1:0] first;
  logic [ELEM_W-1:0] elem;
  logic [ELEM_W-1:0] size;
  logic [ADDR_W-1:0] dbreg;
  logic              over;
  scamap_region_e    region;
  modport user (output file, first, elem, size,
                input dbreg, over, region);
  modport map (input file, first, elem, size,
               output dbreg, over, region);
endinterface
`default_nettype wire

/* File: scamap_xlat.sv */
// Local function code to link command/function byte translator
`default_nettype none
module scamap_xlat
  import scamap_pkg::*;
(
  scamap_xlat_if.xlat x
);
  logic       basic;
  logic [9:0] pc;
  logic       ext;

  assign basic = (x.code >= FC_PROT_WR) && (x.code <= FC_UNP_BIT);
  assign x.ascii = (x.code >= FC_RNG_WR_A) && (x.code <= FC_RMW_A);
  // ASCII forms share bytes with their binary twins
  assign pc = x.ascii ? x.code - FC_ASCII_OFS : x.code;
  assign x.cmd = (x.code == FC_PROT_WR)  ? CB_PROT_WR :
                 (x.code == FC_UNP_RD)   ? CB_UNP_RD :
                 (x.code == FC_PROT_BIT) ? CB_PROT_BIT :
                 (x.code == FC_UNP_BIT)  ? CB_UNP_BIT : CB_EXT;
  assign x.fn = (pc == FC_RNG_WR_B) ? FB_RNG_WR :
                (pc == FC_RNG_RD_B) ? FB_RNG_RD :
                (pc == FC_RMW_B)    ? FB_RMW :
                (pc == FC_TLR2)     ? FB_TLR2 :
                (pc == FC_TLR3)     ? FB_TLR3 :
                (pc == FC_TLW2)     ? FB_TLW2 :
                (pc == FC_TLW3)     ? FB_TLW3 :
                (pc == FC_TLWM)     ? FB_TLWM : FB_NONE;
  assign ext = (pc >= FC_RNG_WR_B && pc <= FC_RMW_B) ||
               (pc >= FC_TLR2 && pc <= FC_TLR3) ||
               (pc >= FC_TLW2 && pc <= FC_TLWM);
  assign x.fn_used = ext;
  assign x.known = basic || ext;
endmodule
`default_nettype wire

/* File: scamap_filemap.sv */
// File number and element to database register, plus region decode
`default_nettype none
module scamap_filemap
  import scamap_pkg::*;
(
  scamap_map_if.map m
);
  logic [FILE_W-1:0] diff;
  logic [PROD_W-1:0] prod;
  logic [PROD_W:0]   sum;
  logic              below;
  logic [NUM_RG-1:0] ge;

  assign below = m.file < m.first;
  assign diff  = m.file - m.first;
  assign prod  = diff * m.size;
  assign sum   = {1'b0, prod} + {9'h000, m.elem};
  // Files below the first one or past the top register are refused
  assign m.over  = below || (sum > {11'h000, DB_LAST});
  assign m.dbreg = sum[ADDR_W-1:0];

  for (genvar i = 0; i < NUM_RG; i++) begin : g_rg
    assign ge[i] = m.dbreg >= RG_START[i];
  end
  // Region starts ascend, so the count of passed starts, less one, is the index
  assign m.region = m.over ? RG_NONE :
      scamap_region_e'(4'($countones(ge)) - 4'h1);
endmodule
`default_nettype wire

/* File: scamap_top.sv */
// Serial command translator and remote file address mapper
`default_nettype none
module scamap_top
  import scamap_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [FILE_W-1:0] first_file,
  input  wire logic [ELEM_W-1:0] file_size,
  input  wire logic              cmd_valid,
  input  wire logic [CODE_W-1:0] cmd_code,
  input  wire logic [7:0]        cmd_node,
  input  wire logic [ADDR_W-1:0] cmd_int_addr,
  input  wire logic [6:0]        cmd_count,
  output logic                   tx_valid,
  output logic [7:0]             tx_node,
  output logic [7:0]             tx_cmd,
  output logic [7:0]             tx_fn,
  output logic                   tx_fn_used,
  output logic                   tx_ascii,
  output logic [ADDR_W-1:0]      tx_int_addr,
  output logic [6:0]             tx_count,
  output logic                   cmd_reject,
  output logic                   cmd_bad,
  input  wire logic              rem_valid,
  output logic                   rem_ready,
  input  wire logic              rem_write,
  input  wire logic [FILE_W-1:0] rem_file,
  input  wire logic [ELEM_W-1:0] rem_elem,
  input  wire logic [DATA_W-1:0] rem_wdata,
  output logic                   rem_done,
  output logic                   rem_err,
  output logic [DATA_W-1:0]      rem_rdata,
  output logic [ADDR_W-1:0]      rem_reg,
  output scamap_region_e         rem_region,
  output logic                   db_en,
  output logic                   db_we,
  output logic [ADDR_W-1:0]      db_addr,
  output logic [DATA_W-1:0]      db_wdata,
  input  wire logic [DATA_W-1:0] db_rdata
);
  scamap_xlat_if xi ();
  scamap_map_if  mi ();

  scamap_xlat u_xlat (
    .x (xi.xlat)
  );

  scamap_filemap u_map (
    .m (mi.map)
  );

  // Command list path
  logic send_ok;
  logic send_bad;

  assign xi.code  = cmd_code;
  assign send_ok  = cmd_valid && xi.known;
  assign send_bad = cmd_valid && !xi.known;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid   <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      tx_valid   <= send_ok;
      cmd_reject <= send_bad;
    end
  end

  // Flag stays until a good entry replaces the bad one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_bad <= 1'b0;
    end else if (cmd_valid) begin
      cmd_bad <= !xi.known;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_int_addr <= '0;
      tx_count    <= '0;
      tx_node     <= '0;
      tx_cmd      <= '0;
      tx_fn       <= '0;
      tx_fn_used  <= 1'b0;
      tx_ascii    <= 1'b0;
    end else if (send_ok) begin
      tx_int_addr <= cmd_int_addr;
      tx_count    <= cmd_count;
      tx_node     <= cmd_node;
      tx_cmd      <= xi.cmd;
      tx_fn       <= xi.fn;
      tx_fn_used  <= xi.fn_used;
      tx_ascii    <= xi.ascii;
    end
  end

  // Remote file access path
  scamap_state_e      state;
  scamap_state_e      next_state;
  logic [FILE_W-1:0]  file_q;
  logic [ELEM_W-1:0]  elem_q;
  logic               wr_q;
  logic               over_q;
  scamap_region_e     region_q;
  logic               rem_take;

  assign rem_ready = state == ST_IDLE;
  assign rem_take  = rem_valid && rem_ready;
  assign mi.file   = file_q;
  assign mi.elem   = elem_q;
  // Settings are read only while mapping; keep them steady then
  assign mi.first  = first_file;
  assign mi.size   = file_size;
  // Every region is reachable; only the top bound and files below the first one refuse
  assign db_en = state == ST_ACC && !over_q;
  assign db_we = db_en && wr_q;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (rem_take) next_state = ST_MAP;
      ST_MAP:  next_state = ST_ACC;
      ST_ACC:  next_state = ST_RESP;
      ST_RESP: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_q   <= '0;
      elem_q   <= '0;
      wr_q     <= 1'b0;
      db_wdata <= '0;
    end else if (rem_take) begin
      file_q   <= rem_file;
      elem_q   <= rem_elem;
      wr_q     <= rem_write;
      db_wdata <= rem_wdata;
    end
  end

  // The multiply is registered before the database sees the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      db_addr  <= '0;
      over_q   <= 1'b0;
      region_q <= RG_NONE;
    end else if (state == ST_MAP) begin
      db_addr  <= mi.dbreg;
      over_q   <= mi.over;
      region_q <= mi.region;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_done <= 1'b0;
    end else begin
      rem_done <= state == ST_RESP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_err    <= 1'b0;
      rem_rdata  <= '0;
      rem_reg    <= '0;
      rem_region <= RG_NONE;
    end else if (state == ST_RESP) begin
      rem_err    <= over_q;
      rem_rdata  <= (over_q || wr_q) ? '0 : db_rdata;
      rem_reg    <= db_addr;
      rem_region <= region_q;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic dflt_cfg;
  assign dflt_cfg = first_file == DEF_FIRST_FILE &&
                    file_size == DEF_FILE_SIZE;

  basic_xlat_a: assert property (
    cmd_valid && cmd_code == FC_UNP_BIT |=>
      tx_valid && tx_cmd == CB_UNP_BIT && !tx_fn_used)
    else $error("basic code 4 not sent as 05");

  ext_xlat_a: assert property (
    cmd_valid && cmd_code == FC_RMW_A |=>
      tx_valid && tx_cmd == CB_EXT && tx_fn == FB_RMW && tx_ascii)
    else $error("ASCII read-modify-write mistranslated");

  typed_xlat_a: assert property (
    cmd_valid && cmd_code == FC_TLW2 |=>
      tx_cmd == CB_EXT && tx_fn == FB_TLW2 && tx_fn_used && !tx_ascii)
    else $error("typed write code mistranslated");

  entry_layout_a: assert property (
    send_ok |=> tx_node == $past(cmd_node) &&
      tx_int_addr == $past(cmd_int_addr) &&
      tx_count == $past(cmd_count))
    else $error("entry fields not carried to link");

  file_base_a: assert property (
    rem_take && dflt_cfg && rem_file == DEF_FIRST_FILE + 8'h01 &&
      rem_elem == '0 |-> ##2 db_en && db_addr == DEF_FILE_SIZE[13:0])
    else $error("second file does not start at one file size");

  elem_offset_a: assert property (
    rem_take && rem_file == first_file && rem_elem <= {2'h0, DB_LAST}
      |-> ##2 db_addr == elem_q[ADDR_W-1:0])
    else $error("element not added to file base");

  region_a: assert property (
    rem_done && !rem_err |->
      (rem_reg < RG_START[1]) == (rem_region == RG_USER) &&
      (rem_reg >= RG_START[9]) == (rem_region == RG_RSVD_HI))
    else $error("region decode disagrees with register");

  all_regions_a: assert property (
    rem_take ##2 !over_q |-> db_en ##1 !db_en ##1 rem_done && !rem_err)
    else $error("in-range access not performed");

  bad_code_a: assert property (
    send_bad |=> !tx_valid && cmd_reject && cmd_bad)
    else $error("unsupported code not rejected");

  no_write_a: assert property (
    rem_take ##2 over_q |-> !db_en [*2] ##1 rem_done && rem_err)
    else $error("out-of-range access reached database");

  basic_nofn_a: assert property (
    cmd_valid && cmd_code == FC_PROT_WR |=>
      tx_cmd == CB_PROT_WR && tx_fn == FB_NONE && !tx_fn_used)
    else $error("basic code 1 not sent as 00");

  binary_read_a: assert property (
    cmd_valid && cmd_code == FC_RNG_RD_B |=>
      tx_cmd == CB_EXT && tx_fn == FB_RNG_RD && tx_fn_used && !tx_ascii)
    else $error("binary range read mistranslated");

  masked_write_a: assert property (
    cmd_valid && cmd_code == FC_TLWM |=>
      tx_cmd == CB_EXT && tx_fn == FB_TLWM && tx_fn_used)
    else $error("masked typed write mistranslated");

  held_fields_a: assert property (
    send_bad |=> $stable(tx_cmd) && $stable(tx_fn) && $stable(tx_node))
    else $error("rejected code altered the entry");

  one_answer_a: assert property (
    !(tx_valid && cmd_reject))
    else $error("entry both sent and rejected");

  third_file_a: assert property (
    rem_take && dflt_cfg && rem_file == DEF_FIRST_FILE + 8'h02 &&
      rem_elem == 16'h0005 |-> ##2
      db_addr == DEF_FILE_SIZE[13:0] + DEF_FILE_SIZE[13:0] + 14'h0005)
    else $error("element offset wrong in third file");

  busy_window_a: assert property (
    rem_take |=> !rem_ready [*3] ##1 rem_ready)
    else $error("access window not four cycles");

  done_pulse_a: assert property (
    rem_done |=> !rem_done)
    else $error("answer strobe longer than one cycle");

  write_data_a: assert property (
    db_we |-> db_wdata == $past(rem_wdata, 2))
    else $error("write data not the data taken");

  refused_data_a: assert property (
    rem_done && rem_err |-> rem_rdata == '0 && rem_region == RG_NONE)
    else $error("refused access returned data");

  p1_cmds_a: assert property (
    rem_done && !rem_err && rem_reg >= RG_START[5] &&
      rem_reg < RG_START[6] |-> rem_region == RG_P1_CMDS)
    else $error("port 1 command region misdecoded");

  read_ok_c: cover property (rem_done && !rem_err && rem_region == RG_USER);
  write_cfg_c: cover property (db_we && region_q == RG_P1_SETUP);
  refused_c: cover property (rem_done && rem_err);
  rejected_c: cover property (cmd_bad ##1 (tx_valid && !cmd_bad));
  ascii_sent_c: cover property (tx_valid && tx_ascii);
endmodule
`default_nettype wire

/* File: scamap_db_model.sv */
// Behavioural database memory facing the mapper's access port
`default_nettype none
module scamap_db_model (
  input  wire logic        clk,
  input  wire logic        db_en,
  input  wire logic        db_we,
  input  wire logic [13:0] db_addr,
  input  wire logic [15:0] db_wdata,
  output logic      [15:0] db_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:16383];

  initial begin
    db_rdata = 16'h0000;
  end

  // Read data is good only in the cycle after the strobe.
  // Otherwise it flips, so a late sample shows up as a mismatch.
  always @(posedge clk) begin
    if (db_en && db_we) begin
      mem[db_addr] <= db_wdata;
    end
    if (db_en && !db_we) begin
      db_rdata <= mem[db_addr];
    end else begin
      db_rdata <= ~db_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: scamap_top_test.sv */
// Self-checking bench for the command translator and file address mapper
`default_nettype none
module scamap_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scamap_pkg::*;
  logic              clk, rst_n, cmd_valid, rem_valid, rem_write;
  logic [FILE_W-1:0] first_file, rem_file;
  logic [ELEM_W-1:0] file_size, rem_elem;
  logic [CODE_W-1:0] cmd_code;
  logic [7:0]        cmd_node, tx_node, tx_cmd, tx_fn;
  logic [ADDR_W-1:0] cmd_int_addr, tx_int_addr, rem_reg, db_addr;
  logic [6:0]        cmd_count, tx_count;
  logic              tx_valid, tx_fn_used, tx_ascii, cmd_reject, cmd_bad;
  logic              rem_ready, rem_done, rem_err, db_en, db_we;
  logic [DATA_W-1:0] rem_wdata, rem_rdata, db_wdata, db_rdata;
  scamap_region_e    rem_region;
  int                fail_count, checks, cycles, db_hits;

  scamap_top i_scamap_top (
    .clk(clk), .rst_n(rst_n), .first_file(first_file),
    .file_size(file_size), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_node(cmd_node), .cmd_int_addr(cmd_int_addr),
    .cmd_count(cmd_count), .tx_valid(tx_valid), .tx_node(tx_node),
    .tx_cmd(tx_cmd), .tx_fn(tx_fn), .tx_fn_used(tx_fn_used),
    .tx_ascii(tx_ascii), .tx_int_addr(tx_int_addr), .tx_count(tx_count),
    .cmd_reject(cmd_reject), .cmd_bad(cmd_bad), .rem_valid(rem_valid),
    .rem_ready(rem_ready), .rem_write(rem_write), .rem_file(rem_file),
    .rem_elem(rem_elem), .rem_wdata(rem_wdata), .rem_done(rem_done),
    .rem_err(rem_err), .rem_rdata(rem_rdata), .rem_reg(rem_reg),
    .rem_region(rem_region), .db_en(db_en), .db_we(db_we),
    .db_addr(db_addr), .db_wdata(db_wdata), .db_rdata(db_rdata));

  scamap_db_model i_scamap_db_model (
    .clk(clk), .db_en(db_en), .db_we(db_we), .db_addr(db_addr),
    .db_wdata(db_wdata), .db_rdata(db_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Ceiling is far above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (db_en === 1'b1) db_hits <= db_hits + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("Error at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask

  // One command entry, answered by tx_valid on the next edge
  task automatic cmd_ok(input logic [9:0] code, input logic [7:0] cb,
                        input logic [7:0] fb, input logic fu, input logic as);
    @(posedge clk);
    cmd_valid    <= 1'b1;
    cmd_code     <= code;
    cmd_node     <= code[7:0] ^ 8'h5a;
    cmd_int_addr <= 14'h2000 | 14'(code);
    cmd_count    <= code[6:0];
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk_bit(tx_valid, 1'b1);
    chk_bit(cmd_reject, 1'b0);
    chk_bit(cmd_bad, 1'b0);
    chk_val(16'(tx_cmd), 16'(cb));
    chk_val(16'(tx_fn), 16'(fb));
    chk_bit(tx_fn_used, fu);
    chk_bit(tx_ascii, as);
    chk_val(16'(tx_node), 16'(code[7:0] ^ 8'h5a));
    chk_val(16'(tx_int_addr), 16'(14'h2000 | 14'(code)));
    chk_val(16'(tx_count), 16'(code[6:0]));
  endtask

  // Unsupported code: refused, flagged, previous command byte left as it was
  task automatic cmd_bad_code(input logic [9:0] code);
    logic [7:0] old_cmd;
    old_cmd = tx_cmd;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk_bit(tx_valid, 1'b0);
    chk_bit(cmd_reject, 1'b1);
    chk_bit(cmd_bad, 1'b1);
    chk_val(16'(tx_cmd), 16'(old_cmd));
  endtask

  function automatic logic [3:0] exp_region(input int r);
    if (r < 5000) return 4'h0;
    if (r < 5010) return 4'h1;
    if (r < 5040) return 4'h2;
    if (r < 5070) return 4'h3;
    if (r < 5200) return 4'h4;
    if (r < 6400) return 4'h5;
    if (r < 7600) return 4'h6;
    if (r < 7800) return 4'h7;
    if (r < 8000) return 4'h8;
    return 4'h9;
  endfunction

  // One remote access; the answer is due exactly three edges after taking
  task automatic rem_op(input logic wr, input logic [7:0] file,
                        input logic [15:0] elem, input logic [15:0] data);
    int  reg_no, hits0;
    logic err;
    @(posedge clk);
    rem_valid <= 1'b1;
    rem_write <= wr;
    rem_file  <= file;
    rem_elem  <= elem;
    rem_wdata <= data;
    // Settings driven at the previous edge have landed by now
    reg_no = (int'(file) - int'(first_file)) * int'(file_size) + int'(elem);
    err    = (file < first_file) || (reg_no > 9999);
    do @(posedge clk); while (!(rem_ready === 1'b1) && cycles < 4990);
    hits0 = db_hits;
    rem_valid <= 1'b0;
    rem_wdata <= ~data;
    repeat (3) begin
      #1 chk_bit(rem_done, 1'b0);
      chk_bit(rem_ready, 1'b0);
      @(posedge clk);
    end
    #1;
    chk_bit(rem_done, 1'b1);
    chk_bit(rem_ready, 1'b1);
    chk_bit(rem_err, err);
    if (err) begin
      chk_val(16'(rem_region), 16'h000f);
      chk_val(16'(db_hits - hits0), 16'h0000);
    end else begin
      chk_val(16'(rem_reg), 16'(reg_no));
      chk_val(16'(rem_region), 16'(exp_region(reg_no)));
      chk_val(rem_rdata, wr ? 16'h0000 : data);
      chk_val(16'(db_hits - hits0), 16'h0001);
      if (wr) chk_val(i_scamap_db_model.mem[reg_no], data);
    end
  endtask

  task automatic rem_pair(input logic [7:0] file, input logic [15:0] elem);
    logic [15:0] d;
    d = {file, elem[7:0]} ^ 16'ha5c3;
    rem_op(1'b1, file, elem, d);
    rem_op(1'b0, file, elem, d);
  endtask

  initial begin
    rst_n = 1'b0;
    first_file = DEF_FIRST_FILE;
    file_size = DEF_FILE_SIZE;
    {cmd_valid, rem_valid, rem_write} = 3'b000;
    cmd_code = 10'h000;
    cmd_node = 8'h00;
    cmd_int_addr = 14'h0000;
    cmd_count = 7'h00;
    rem_file = 8'h00;
    rem_elem = 16'h0000;
    rem_wdata = 16'h0000;
    {fail_count, checks, cycles, db_hits} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cmd_ok(10'd1, 8'h00, 8'h00, 1'b0, 1'b0);
    cmd_ok(10'd2, 8'h01, 8'h00, 1'b0, 1'b0);
    cmd_ok(10'd3, 8'h02, 8'h00, 1'b0, 1'b0);
    cmd_ok(10'd4, 8'h05, 8'h00, 1'b0, 1'b0);
    cmd_bad_code(10'd5);
    cmd_ok(10'd100, 8'h0f, 8'h00, 1'b1, 1'b0);
    cmd_ok(10'd101, 8'h0f, 8'h01, 1'b1, 1'b0);
    cmd_ok(10'd102, 8'h0f, 8'h26, 1'b1, 1'b0);
    cmd_bad_code(10'd103);
    cmd_ok(10'd150, 8'h0f, 8'h00, 1'b1, 1'b1);
    cmd_ok(10'd151, 8'h0f, 8'h01, 1'b1, 1'b1);
    cmd_ok(10'd152, 8'h0f, 8'h26, 1'b1, 1'b1);
    cmd_bad_code(10'd0);
    cmd_ok(10'd501, 8'h0f, 8'ha1, 1'b1, 1'b0);
    cmd_ok(10'd502, 8'h0f, 8'ha2, 1'b1, 1'b0);
    cmd_ok(10'd509, 8'h0f, 8'ha9, 1'b1, 1'b0);
    cmd_ok(10'd510, 8'h0f, 8'haa, 1'b1, 1'b0);
    cmd_ok(10'd511, 8'h0f, 8'hab, 1'b1, 1'b0);
    cmd_bad_code(10'd512);
    rem_pair(8'd8, 16'd0);
    rem_pair(8'd9, 16'd5);
    rem_pair(8'd7, 16'd0);
    rem_pair(8'd31, 16'd199);
    rem_pair(8'd32, 16'd0);
    rem_pair(8'd32, 16'd10);
    rem_pair(8'd32, 16'd40);
    rem_pair(8'd32, 16'd70);
    rem_pair(8'd33, 16'd0);
    rem_pair(8'd39, 16'd0);
    rem_pair(8'd45, 16'd0);
    rem_pair(8'd46, 16'd0);
    rem_pair(8'd56, 16'd199);
    rem_op(1'b1, 8'd57, 16'd0, 16'h1234);
    rem_op(1'b1, 8'd6, 16'd3, 16'h1234);
    rem_op(1'b0, 8'd56, 16'd200, 16'h0000);
    @(posedge clk);
    first_file <= 8'd3;
    file_size  <= 16'd16;
    rem_pair(8'd5, 16'd2);
    rem_pair(8'd3, 16'd9);
    rem_op(1'b1, 8'd2, 16'd0, 16'h4321);
    print_verdict();
  end
endmodule
`default_nettype wire
